// ==== rtl/flash_self_prog_pkg.sv ====
// Constants and register map of the flash self-programming control block
package flash_self_prog_pkg;
   localparam int          ADDR_W          = 12;
   localparam int          DATA_W          = 32;
   localparam int          FLASH_ADDR_W    = 20;
   localparam int          BLOCK_SHIFT     = 12;
   localparam int          BLOCK_IDX_W     = 4;
   localparam int          SWAP_BIT        = 3;
   localparam int          RAM_ADDR_W      = 32;
   localparam logic [31:0] RAM_START_DEF   = 32'hFFFF_A000;
   localparam logic [31:0] NMI_RAM_OFFSET  = 32'h0000_0000;
   localparam logic [31:0] MASK_RAM_OFFSET = 32'h0000_0004;
   localparam logic [11:0] REG_CTRL        = 12'h000;
   localparam logic [11:0] REG_STATUS      = 12'h004;
   localparam logic [11:0] REG_SWAP        = 12'h008;
   localparam int          CTRL_SELF_BIT   = 0;
   localparam int          CTRL_WREQ_BIT   = 1;
   localparam int          ST_SELF_BIT     = 0;
   localparam int          ST_WEN_BIT      = 1;
   localparam int          ST_PROTECT_BIT  = 2;
   localparam int          ST_EXTPROG_BIT  = 3;
   localparam int          ST_BLOCKED_BIT  = 4;
   localparam int          ST_SETPROHIB_BIT = 5;
   localparam int          ST_SWAP_BIT     = 6;
   localparam logic [1:0]  CTRL_RESET      = 2'h0;
endpackage

// ==== rtl/sync_pair_if.sv ====
// Interface carrying synchronised mode pins between modules
`timescale 1ns/10ps
interface sync_pair_if;
   logic protect;
   logic mode2;
   modport src (output protect, output mode2);
   modport dst (input  protect, input  mode2);
endinterface

// ==== rtl/pin_sync.sv ====
// Two-stage synchroniser for the two mode pins
`timescale 1ns/10ps
module pin_sync (
   input  wire logic clk_sys_in,
   input  wire logic sys_rst_in,
   input  wire logic clk_en_in,
   input  wire logic protect_pin_in,
   input  wire logic mode2_pin_in,
   sync_pair_if.src  pins
);
   logic [1:0] stage_a;
   logic [1:0] stage_b;
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         stage_a <= 2'h0;
         stage_b <= 2'h0;
      end else if (clk_en_in) begin
         stage_a <= {mode2_pin_in, protect_pin_in};
         stage_b <= stage_a;
      end
   end
   assign pins.protect = stage_b[0];
   assign pins.mode2   = stage_b[1];
endmodule

// ==== rtl/flash_self_program_control.sv ====
// Flash self-programming control: boot swap, vector redirect, write protect
`timescale 1ns/10ps
module flash_self_program_control #(
   parameter logic [31:0] RAM_START = flash_self_prog_pkg::RAM_START_DEF
) (
   input  wire logic        clk_sys_in,
   input  wire logic        sys_rst_in,
   input  wire logic        clk_en_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        flash_write_protect_pin_in,
   input  wire logic        second_mode_select_pin_in,
   input  wire logic [19:0] cpu_addr_in,
   output logic      [19:0] phys_addr_out,
   input  wire logic        fetch_req_in,
   output logic             fetch_grant_out,
   output logic             fetch_blocked_out,
   input  wire logic        wr_req_in,
   output logic             wr_allow_out,
   input  wire logic        nmi_ack_in,
   input  wire logic        mask_ack_in,
   output logic             vector_redirect_out,
   output logic      [31:0] vector_addr_out,
   output logic             ext_prog_mode_out,
   output logic             set_prohibited_out
);
   typedef enum logic [1:0] {ST_INIT, ST_NORMAL, ST_EXTPROG, ST_PROHIB} mode_t;

   sync_pair_if pins ();
   pin_sync u_sync (
      .clk_sys_in     (clk_sys_in),
      .sys_rst_in     (sys_rst_in),
      .clk_en_in      (clk_en_in),
      .protect_pin_in (flash_write_protect_pin_in),
      .mode2_pin_in   (second_mode_select_pin_in),
      .pins           (pins)
   );

   mode_t       mode;
   logic [1:0]  ctrl;
   logic        swap;
   logic [1:0]  init_wait;
   logic        self_prog;
   logic        acc;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction

   assign acc       = psel_in && penable_in && clk_en_in;
   assign self_prog = ctrl[flash_self_prog_pkg::CTRL_SELF_BIT];
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in &&
                        !(hit(paddr_in, flash_self_prog_pkg::REG_CTRL) ||
                          hit(paddr_in, flash_self_prog_pkg::REG_STATUS) ||
                          hit(paddr_in, flash_self_prog_pkg::REG_SWAP));

   // Control register
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         ctrl <= flash_self_prog_pkg::CTRL_RESET;
      end else if (acc && pwrite_in && hit(paddr_in, flash_self_prog_pkg::REG_CTRL)) begin
         ctrl <= pwdata_in[1:0];
      end
   end

   // Swap register, changed only by explicit write
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         swap <= 1'b0;
      end else if (acc && pwrite_in && hit(paddr_in, flash_self_prog_pkg::REG_SWAP)) begin
         swap <= pwdata_in[0];
      end
   end

   // Mode capture after reset release, once pins are synchronised
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         mode      <= ST_INIT;
         init_wait <= 2'h0;
      end else if (clk_en_in) begin
         case (mode)
            ST_INIT: begin
               if (init_wait == 2'h3) begin
                  if (!pins.protect) begin
                     mode <= ST_NORMAL;
                  end else if (!pins.mode2) begin
                     mode <= ST_EXTPROG;
                  end else begin
                     mode <= ST_PROHIB;
                  end
               end else begin
                  init_wait <= init_wait + 2'h1;
               end
            end
            ST_NORMAL:  mode <= ST_NORMAL;
            ST_EXTPROG: mode <= ST_EXTPROG;
            ST_PROHIB:  mode <= ST_PROHIB;
            default:    mode <= ST_INIT;
         endcase
      end
   end

   assign ext_prog_mode_out  = (mode == ST_EXTPROG);
   assign set_prohibited_out = (mode == ST_PROHIB);

   // Address mapping with block swap
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         phys_addr_out <= 20'h00000;
      end else if (clk_en_in) begin
         phys_addr_out <= cpu_addr_in;
         phys_addr_out[flash_self_prog_pkg::BLOCK_SHIFT + flash_self_prog_pkg::SWAP_BIT] <=
            cpu_addr_in[flash_self_prog_pkg::BLOCK_SHIFT + flash_self_prog_pkg::SWAP_BIT]
            ^ swap;
      end
   end

   // Fetch gating
   assign fetch_blocked_out = self_prog && fetch_req_in;
   assign fetch_grant_out   = fetch_req_in && !self_prog;

   // Write protection from pin level
   assign wr_allow_out = wr_req_in && self_prog && pins.protect &&
                         ctrl[flash_self_prog_pkg::CTRL_WREQ_BIT];

   // Interrupt vector redirect to RAM
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         vector_redirect_out <= 1'b0;
         vector_addr_out     <= 32'h0000_0000;
      end else if (clk_en_in) begin
         vector_redirect_out <= self_prog && (nmi_ack_in || mask_ack_in);
         if (nmi_ack_in) begin
            vector_addr_out <= RAM_START + flash_self_prog_pkg::NMI_RAM_OFFSET;
         end else begin
            vector_addr_out <= RAM_START + flash_self_prog_pkg::MASK_RAM_OFFSET;
         end
      end
   end

   // Read data
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         prdata_out <= 32'h0000_0000;
      end else if (clk_en_in && psel_in && !penable_in && !pwrite_in) begin
         prdata_out <= 32'h0000_0000;
         if (hit(paddr_in, flash_self_prog_pkg::REG_CTRL)) begin
            prdata_out[1:0] <= ctrl;
         end else if (hit(paddr_in, flash_self_prog_pkg::REG_SWAP)) begin
            prdata_out[0] <= swap;
         end else if (hit(paddr_in, flash_self_prog_pkg::REG_STATUS)) begin
            prdata_out[flash_self_prog_pkg::ST_SELF_BIT]      <= self_prog;
            prdata_out[flash_self_prog_pkg::ST_WEN_BIT]       <= self_prog && pins.protect;
            prdata_out[flash_self_prog_pkg::ST_PROTECT_BIT]   <= pins.protect;
            prdata_out[flash_self_prog_pkg::ST_EXTPROG_BIT]   <= (mode == ST_EXTPROG);
            prdata_out[flash_self_prog_pkg::ST_BLOCKED_BIT]   <= self_prog;
            prdata_out[flash_self_prog_pkg::ST_SETPROHIB_BIT] <= (mode == ST_PROHIB);
            prdata_out[flash_self_prog_pkg::ST_SWAP_BIT]      <= swap;
         end
      end
   end

   a_swap_map: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      clk_en_in |=>
      phys_addr_out[flash_self_prog_pkg::BLOCK_SHIFT + flash_self_prog_pkg::SWAP_BIT] ==
      ($past(cpu_addr_in[flash_self_prog_pkg::BLOCK_SHIFT + flash_self_prog_pkg::SWAP_BIT])
       ^ $past(swap)))
      else $error("swap mapping wrong");
   a_fetch_block: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      self_prog |-> !fetch_grant_out)
      else $error("fetch granted in self-programming");
   a_nmi_vector: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (clk_en_in && self_prog && nmi_ack_in) |=>
      vector_redirect_out && vector_addr_out == RAM_START)
      else $error("nmi vector wrong");
   a_mask_vector: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (clk_en_in && self_prog && mask_ack_in && !nmi_ack_in) |=>
      vector_redirect_out &&
      vector_addr_out == RAM_START + flash_self_prog_pkg::MASK_RAM_OFFSET)
      else $error("maskable vector wrong");
   a_write_protect: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      wr_allow_out |-> pins.protect && self_prog)
      else $error("write allowed without protect pin");
   a_ext_mode: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (mode == ST_INIT && init_wait == 2'h3 && clk_en_in && pins.protect && !pins.mode2)
      |=> ext_prog_mode_out)
      else $error("external mode not entered");
   a_swap_hold: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      !(acc && pwrite_in && hit(paddr_in, flash_self_prog_pkg::REG_SWAP))
      |=> $stable(swap))
      else $error("swap changed without write");
   a_mode_stick: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (mode == ST_NORMAL) |=> (mode == ST_NORMAL))
      else $error("mode left normal");
endmodule

// ==== bench/flash_self_program_control_tb.sv ====
// Self-checking testbench for the flash self-programming control block
`timescale 1ns/10ps
module flash_self_program_control_tb;
   localparam logic [31:0] RS = flash_self_prog_pkg::RAM_START_DEF;
   logic        clk, rst, psel, pen, pwr, ready, err, errs, prot, mode2;
   logic        freq, grant, blocked, wreq, allow, nmi, mack, redir, extp, prohib, cen;
   logic [11:0] paddr;
   logic [19:0] caddr, phys;
   logic [31:0] pwdata, prdata, rdata, vaddr;
   int          error_cnt, cmp_count;

   flash_self_program_control flash_self_program_control_i (
      .clk_sys_in(clk), .sys_rst_in(rst), .clk_en_in(cen), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(ready), .pslverr_out(err),
      .flash_write_protect_pin_in(prot), .second_mode_select_pin_in(mode2),
      .cpu_addr_in(caddr), .phys_addr_out(phys), .fetch_req_in(freq),
      .fetch_grant_out(grant), .fetch_blocked_out(blocked), .wr_req_in(wreq),
      .wr_allow_out(allow), .nmi_ack_in(nmi), .mask_ack_in(mack),
      .vector_redirect_out(redir), .vector_addr_out(vaddr),
      .ext_prog_mode_out(extp), .set_prohibited_out(prohib));

   always #12.5 clk = ~clk;

   task check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      do begin
         @(posedge clk);
      end while (ready !== 1'h1);
      rdata = prdata;
      errs = err;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask

   task do_reset(input logic p, input logic m);
      @(posedge clk);
      prot <= p;
      mode2 <= m;
      rst <= 1'h1;
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      repeat (12) @(posedge clk);
   endtask

   task pulse(input logic n, input logic m);
      @(posedge clk);
      nmi <= n;
      mack <= m;
      @(posedge clk);
      nmi <= 1'h0;
      mack <= 1'h0;
      #1;
   endtask

   task t_regs;
      apb(1'h1, flash_self_prog_pkg::REG_STATUS, 32'hFFFF_FFFF);
      apb(1'h0, flash_self_prog_pkg::REG_STATUS, 32'h0);
      check(rdata, 32'h0);
      apb(1'h0, flash_self_prog_pkg::REG_SWAP, 32'h0);
      check(rdata, 32'h0);
      apb(1'h0, 12'h00C, 32'h0);
      check({errs, rdata[30:0]}, 32'h8000_0000);
      $display("test regs done");
   endtask

   task t_swap;
      caddr <= 20'h0_3456;
      apb(1'h1, flash_self_prog_pkg::REG_SWAP, 32'h1);
      repeat (2) @(posedge clk);
      check(32'(phys), 32'h0000_B456);
      apb(1'h0, flash_self_prog_pkg::REG_SWAP, 32'h0);
      check(rdata, 32'h0000_0001);
      apb(1'h0, flash_self_prog_pkg::REG_STATUS, 32'h0);
      check(rdata, 32'h0000_0040);
      caddr <= 20'h0_F123;
      apb(1'h1, flash_self_prog_pkg::REG_CTRL, 32'h3);
      apb(1'h1, flash_self_prog_pkg::REG_CTRL, 32'h0);
      check(32'(phys), 32'h0000_7123);
      apb(1'h1, flash_self_prog_pkg::REG_SWAP, 32'h0);
      repeat (2) @(posedge clk);
      check(32'(phys), 32'h0000_F123);
      cen <= 1'h0;
      caddr <= 20'h0_1111;
      repeat (2) @(posedge clk);
      check(32'(phys), 32'h0000_F123);
      cen <= 1'h1;
      $display("test swap done");
   endtask

   task t_fetch;
      freq <= 1'h1;
      apb(1'h1, flash_self_prog_pkg::REG_CTRL, 32'h1);
      #1;
      check(32'({grant, blocked}), 32'h1);
      apb(1'h1, flash_self_prog_pkg::REG_CTRL, 32'h0);
      #1;
      check(32'({grant, blocked}), 32'h2);
      $display("test fetch done");
   endtask

   task t_vec;
      apb(1'h1, flash_self_prog_pkg::REG_CTRL, 32'h1);
      pulse(1'h1, 1'h1);
      check(32'(redir), 32'h1);
      check(vaddr, RS);
      pulse(1'h0, 1'h1);
      check(32'(redir), 32'h1);
      check(vaddr, RS + 32'h4);
      @(posedge clk);
      #1;
      check(32'(redir), 32'h0);
      apb(1'h1, flash_self_prog_pkg::REG_CTRL, 32'h0);
      pulse(1'h1, 1'h0);
      check(32'(redir), 32'h0);
      $display("test vectors done");
   endtask

   task t_wr;
      @(posedge clk);
      freq <= 1'h0;
      wreq <= 1'h1;
      apb(1'h1, flash_self_prog_pkg::REG_CTRL, 32'h3);
      #1;
      check(32'(allow), 32'h0);
      @(posedge clk);
      prot <= 1'h1;
      repeat (4) @(posedge clk);
      #1;
      check(32'(allow), 32'h1);
      apb(1'h0, flash_self_prog_pkg::REG_STATUS, 32'h0);
      check(rdata, 32'h0000_0017);
      apb(1'h0, flash_self_prog_pkg::REG_CTRL, 32'h0);
      check(rdata, 32'h0000_0003);
      apb(1'h1, flash_self_prog_pkg::REG_CTRL, 32'h1);
      #1;
      check(32'(allow), 32'h0);
      @(posedge clk);
      prot <= 1'h0;
      apb(1'h1, flash_self_prog_pkg::REG_CTRL, 32'h3);
      repeat (4) @(posedge clk);
      #1;
      check(32'(allow), 32'h0);
      $display("test write protect done");
   endtask

   task t_mode;
      do_reset(1'h1, 1'h0);
      check(32'({extp, prohib}), 32'h2);
      do_reset(1'h1, 1'h1);
      check(32'({extp, prohib}), 32'h1);
      do_reset(1'h0, 1'h1);
      check(32'({extp, prohib}), 32'h0);
      $display("test mode done");
   endtask

   task finish_test;
      $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      clk = 1'h0;
      rst = 1'h1;
      {psel, pen, pwr, prot, mode2, freq, wreq, nmi, mack} = 9'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      caddr = 20'h0;
      cen = 1'h1;
      error_cnt = 0;
      cmp_count = 0;
      do_reset(1'h0, 1'h0);
      t_regs();
      t_swap();
      t_fetch();
      t_vec();
      t_wr();
      t_mode();
      finish_test();
   end

   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
endmodule
